// *** hdl/tcc_top.sv ***
// Top of the timer capture/compare block with its AXI4-Lite slave.
// Assumes software does 16-bit access via the shared temporary byte.
//
// Behaviour
// - high byte first, low write loads both
// - low read latches high; compare bypasses
// - source switch may capture; clear flag
// - shared synchroniser and edge detector
// - filter adds four cycles delay
// - capture input off in capture-top modes
// - driven port pin can trigger capture
// - filter changes after four agreeing samples
// - filter enabled by control bit
// - filter on undivided system clock
// - new capture always overwrites value
// - write one clears capture flag
// - per-channel continuous equality compare
// - match sets flag next timer tick
// - enabled flag raises interrupt request
// - flag clears on service or write
// - waveform output by mode fields
//
// Local design decisions: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
module tcc_top (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Capture sources
  input wire logic capture_pin_in,
  input wire logic comparator_out,
  output logic capture_pin_out,
  output logic capture_pin_oe,
  // Interrupt service acknowledges
  input wire logic cmp_a_ack,
  input wire logic cmp_b_ack,
  input wire logic cap_ack,
  // Requests and waveforms
  output logic cmp_a_irq,
  output logic cmp_b_irq,
  output logic cap_irq,
  output logic wave_a,
  output logic wave_b
);
  typedef enum logic [1:0] {TCC_W_IDLE, TCC_W_RESP} tcc_wstate_t;

  logic [7:0] ctrl_a_q, ctrl_b_q, mask_q, acmp_q, pin_q, temp_q, awaddr_q, wdata_q, rd_byte;
  logic [15:0] timer_count_q, capture_value_q, cmp_a_q, cmp_b_q, top_val;
  logic cap_flag_q, cmpa_flag_q, cmpb_flag_q, tick, cap_top, cap_edge, match_a, match_b;
  logic [9:0] presc_q;
  logic [3:0] wave_mode_sel;
  logic cap_src, cap_sync1_q, cap_sync2_q, acmp_sync1_q, acmp_sync2_q;
  logic aw_have_q, w_have_q, wr_fire, rd_fire, rd_ok, wr_ok;
  tcc_wstate_t wstate_q;

  // Byte write decode used in several processes
  function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] target);
    wr_hit = (a == target);
  endfunction : wr_hit

  // ****************************************
  // Timer base
  // ****************************************
  assign wave_mode_sel = {ctrl_b_q[tcc_pkg::TCC_B_WGMH_LSB+1 -: 2],
                          ctrl_a_q[tcc_pkg::TCC_A_WGM_LSB+1 -: 2]};
  assign cap_top = (wave_mode_sel == tcc_pkg::TCC_WGM_CAPTOP_A)
                 | (wave_mode_sel == tcc_pkg::TCC_WGM_CAPTOP_B)
                 | (wave_mode_sel == tcc_pkg::TCC_WGM_CAPTOP_C)
                 | (wave_mode_sel == tcc_pkg::TCC_WGM_CAPTOP_D);
  assign top_val = cap_top ? capture_value_q : ((wave_mode_sel == 4'h4) ? cmp_a_q : 16'hFFFF);

  // Prescaler tick; the counter and both compare channels see it, the filter does not
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      presc_q <= 10'h000;
    end else begin
      presc_q <= presc_q + 10'h001;
    end
  end

  always_comb begin
    case (ctrl_b_q[2:0])
      3'h1: tick = 1'b1;
      3'h2: tick = (presc_q[2:0] == 3'h7);
      3'h3: tick = (presc_q[5:0] == 6'h3F);
      3'h4: tick = (presc_q[7:0] == 8'hFF);
      3'h5: tick = (presc_q == 10'h3FF);
      default: tick = 1'b0;
    endcase
  end

  // ****************************************
  // Capture source synchronisers
  // ****************************************
  // pin reads back the port drive when driven
  assign cap_src = acmp_q[tcc_pkg::TCC_ACMP_SEL] ? acmp_sync2_q : cap_sync2_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_sync1_q <= 1'b0;
      cap_sync2_q <= 1'b0;
      acmp_sync1_q <= 1'b0;
      acmp_sync2_q <= 1'b0;
    end else begin
      cap_sync1_q <= capture_pin_in;
      cap_sync2_q <= cap_sync1_q;
      acmp_sync1_q <= comparator_out;
      acmp_sync2_q <= acmp_sync1_q;
    end
  end

  // same filter and edge path for both sources
  tcc_input_filter u_filter (
    .aclk(aclk),
    .aresetn(aresetn),
    .enable(~cap_top),
    .filter_on(ctrl_b_q[tcc_pkg::TCC_B_NOISE]),
    .rising_sel(ctrl_b_q[tcc_pkg::TCC_B_EDGE]),
    .raw_in(cap_src),
    .edge_pulse(cap_edge)
  );

  // ****************************************
  // Compare channels
  // ****************************************
  tcc_compare_chan u_cmp_a (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .count(timer_count_q),
    .compare(cmp_a_q),
    .at_bottom(timer_count_q == 16'h0000),
    .wave_mode(wave_mode_sel),
    .out_mode(ctrl_a_q[tcc_pkg::TCC_A_COMA_LSB+1 -: 2]),
    .match_pulse(match_a),
    .wave_out(wave_a)
  );

  tcc_compare_chan u_cmp_b (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .count(timer_count_q),
    .compare(cmp_b_q),
    .at_bottom(timer_count_q == 16'h0000),
    .wave_mode(wave_mode_sel),
    .out_mode(ctrl_a_q[tcc_pkg::TCC_A_COMB_LSB+1 -: 2]),
    .match_pulse(match_b),
    .wave_out(wave_b)
  );

  // ****************************************
  // AXI4-Lite write channel
  // ****************************************
  assign wr_fire = aw_have_q & w_have_q & (wstate_q == TCC_W_IDLE);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= tcc_pkg::TCC_RST_BYTE;
      wdata_q <= tcc_pkg::TCC_RST_BYTE;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= tcc_pkg::TCC_RESP_OKAY;
      wstate_q <= TCC_W_IDLE;
    end else begin
      s_axi_awready <= ~aw_have_q & ~s_axi_awready & (wstate_q == TCC_W_IDLE);
      s_axi_wready <= ~w_have_q & ~s_axi_wready & (wstate_q == TCC_W_IDLE);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_have_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_have_q <= 1'b1;
        wdata_q <= s_axi_wstrb[0] ? s_axi_wdata[7:0] : 8'h00;
      end
      case (wstate_q)
        TCC_W_IDLE: begin
          if (wr_fire) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? tcc_pkg::TCC_RESP_OKAY : tcc_pkg::TCC_RESP_SLVERR;
            wstate_q <= TCC_W_RESP;
          end
        end
        TCC_W_RESP: begin
          if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            wstate_q <= TCC_W_IDLE;
          end
        end
        default: wstate_q <= TCC_W_IDLE;
      endcase
    end
  end

  assign wr_ok = (awaddr_q[1:0] == 2'h0) & (awaddr_q <= tcc_pkg::TCC_ADDR_PIN);

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_a_q <= tcc_pkg::TCC_RST_BYTE;
      ctrl_b_q <= tcc_pkg::TCC_RST_BYTE;
      mask_q <= tcc_pkg::TCC_RST_BYTE;
      acmp_q <= tcc_pkg::TCC_RST_BYTE;
      pin_q <= tcc_pkg::TCC_RST_BYTE;
    end else if (wr_fire) begin
      // filter enable lives in control B
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CTRL_A)) ctrl_a_q <= wdata_q;
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CTRL_B)) ctrl_b_q <= wdata_q;
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_MASK)) mask_q <= wdata_q;
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_ACMP)) acmp_q <= wdata_q;
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_PIN)) pin_q <= wdata_q;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_pin_out <= 1'b0;
      capture_pin_oe <= 1'b0;
    end else begin
      capture_pin_out <= pin_q[tcc_pkg::TCC_PIN_DRIVE];
      capture_pin_oe <= pin_q[tcc_pkg::TCC_PIN_OUTEN];
    end
  end

  // ****************************************
  // Temporary byte and 16-bit registers
  // ****************************************
  // high byte parked; low read latches high
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      temp_q <= tcc_pkg::TCC_RST_BYTE;
    end else if (wr_fire & (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CNT_H)
                 | wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CAP_H)
                 | wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CMPA_H)
                 | wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CMPB_H))) begin
      temp_q <= wdata_q;
    end else if (rd_fire & (s_axi_araddr == tcc_pkg::TCC_ADDR_CNT_L)) begin
      temp_q <= timer_count_q[15:8];
    end else if (rd_fire & (s_axi_araddr == tcc_pkg::TCC_ADDR_CAP_L)) begin
      temp_q <= capture_value_q[15:8];
    end
  end

  // Counter: software load wins over counting
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_count_q <= tcc_pkg::TCC_RST_WORD;
    end else if (wr_fire & wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CNT_L)) begin
      timer_count_q <= {temp_q, wdata_q};
    end else if (tick) begin
      timer_count_q <= (timer_count_q >= top_val) ? 16'h0000 : timer_count_q + 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      capture_value_q <= tcc_pkg::TCC_RST_WORD;
    end else if (cap_edge) begin
      capture_value_q <= timer_count_q;
    end else if (wr_fire & wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CAP_L) & cap_top) begin
      capture_value_q <= {temp_q, wdata_q};
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_q <= tcc_pkg::TCC_RST_WORD;
      cmp_b_q <= tcc_pkg::TCC_RST_WORD;
    end else if (wr_fire) begin
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CMPA_L)) cmp_a_q <= {temp_q, wdata_q};
      if (wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_CMPB_L)) cmp_b_q <= {temp_q, wdata_q};
    end
  end

  // ****************************************
  // Flags and requests
  // ****************************************
  // write-one clears; set wins over clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_flag_q <= 1'b0;
      cmpa_flag_q <= 1'b0;
      cmpb_flag_q <= 1'b0;
    end else begin
      // flag with the capture; spurious edges flagged too
      if (cap_edge) begin
        cap_flag_q <= 1'b1;
      end else if (cap_ack | (wr_fire & wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_FLAG)
                   & wdata_q[tcc_pkg::TCC_F_CAP])) begin
        cap_flag_q <= 1'b0;
      end
      // flag on the tick after the match
      if (match_a) begin
        cmpa_flag_q <= 1'b1;
      end else if (cmp_a_ack | (wr_fire & wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_FLAG)
                   & wdata_q[tcc_pkg::TCC_F_CMPA])) begin
        cmpa_flag_q <= 1'b0;
      end
      if (match_b) begin
        cmpb_flag_q <= 1'b1;
      end else if (cmp_b_ack | (wr_fire & wr_hit(awaddr_q, tcc_pkg::TCC_ADDR_FLAG)
                   & wdata_q[tcc_pkg::TCC_F_CMPB])) begin
        cmpb_flag_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_a_irq <= 1'b0;
      cmp_b_irq <= 1'b0;
      cap_irq <= 1'b0;
    end else begin
      cmp_a_irq <= cmpa_flag_q & mask_q[tcc_pkg::TCC_F_CMPA];
      cmp_b_irq <= cmpb_flag_q & mask_q[tcc_pkg::TCC_F_CMPB];
      cap_irq <= cap_flag_q & mask_q[tcc_pkg::TCC_F_CAP];
    end
  end

  // ****************************************
  // AXI4-Lite read channel
  // ****************************************
  assign rd_fire = s_axi_arvalid & s_axi_arready;

  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      tcc_pkg::TCC_ADDR_CTRL_A: rd_byte = ctrl_a_q;
      tcc_pkg::TCC_ADDR_CTRL_B: rd_byte = ctrl_b_q;
      tcc_pkg::TCC_ADDR_MASK: rd_byte = mask_q;
      tcc_pkg::TCC_ADDR_FLAG: rd_byte = {2'b00, cap_flag_q, 2'b00, cmpb_flag_q, cmpa_flag_q, 1'b0};
      tcc_pkg::TCC_ADDR_CNT_L: rd_byte = timer_count_q[7:0];
      tcc_pkg::TCC_ADDR_CNT_H: rd_byte = temp_q;
      tcc_pkg::TCC_ADDR_CAP_L: rd_byte = capture_value_q[7:0];
      tcc_pkg::TCC_ADDR_CAP_H: rd_byte = temp_q;
      tcc_pkg::TCC_ADDR_CMPA_L: rd_byte = cmp_a_q[7:0];
      tcc_pkg::TCC_ADDR_CMPA_H: rd_byte = cmp_a_q[15:8];
      tcc_pkg::TCC_ADDR_CMPB_L: rd_byte = cmp_b_q[7:0];
      tcc_pkg::TCC_ADDR_CMPB_H: rd_byte = cmp_b_q[15:8];
      tcc_pkg::TCC_ADDR_ACMP: rd_byte = acmp_q;
      tcc_pkg::TCC_ADDR_PIN: rd_byte = {pin_q[7:1], cap_sync2_q};
      default: begin
        rd_byte = 8'h00;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= tcc_pkg::TCC_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid & ~s_axi_arvalid ? 1'b0
                     : ~s_axi_arready & ~s_axi_rvalid;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_ok ? tcc_pkg::TCC_RESP_OKAY : tcc_pkg::TCC_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : tcc_top

// *** hdl/tcc_pkg.sv ***
// Package for the 16-bit timer capture/compare block.
// Assumes a 32-bit AXI4-Lite slave, one clock, byte-wide 16-bit access.
package tcc_pkg;
  // ****************************************
  // Register byte addresses
  // ****************************************
  localparam logic [7:0] TCC_ADDR_CTRL_A = 8'h00;
  localparam logic [7:0] TCC_ADDR_CTRL_B = 8'h04;
  localparam logic [7:0] TCC_ADDR_MASK = 8'h08;
  localparam logic [7:0] TCC_ADDR_FLAG = 8'h0C;
  localparam logic [7:0] TCC_ADDR_CNT_L = 8'h10;
  localparam logic [7:0] TCC_ADDR_CNT_H = 8'h14;
  localparam logic [7:0] TCC_ADDR_CAP_L = 8'h18;
  localparam logic [7:0] TCC_ADDR_CAP_H = 8'h1C;
  localparam logic [7:0] TCC_ADDR_CMPA_L = 8'h20;
  localparam logic [7:0] TCC_ADDR_CMPA_H = 8'h24;
  localparam logic [7:0] TCC_ADDR_CMPB_L = 8'h28;
  localparam logic [7:0] TCC_ADDR_CMPB_H = 8'h2C;
  localparam logic [7:0] TCC_ADDR_ACMP = 8'h30;
  localparam logic [7:0] TCC_ADDR_PIN = 8'h34;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int TCC_A_COMB_LSB = 4;
  localparam int TCC_A_COMA_LSB = 6;
  localparam int TCC_A_WGM_LSB = 0;
  localparam int TCC_B_CS_LSB = 0;
  localparam int TCC_B_WGMH_LSB = 3;
  localparam int TCC_B_EDGE = 6;
  localparam int TCC_B_NOISE = 7;
  localparam int TCC_F_CMPA = 1;
  localparam int TCC_F_CMPB = 2;
  localparam int TCC_F_CAP = 5;
  localparam int TCC_ACMP_SEL = 2;
  localparam int TCC_PIN_DRIVE = 0;
  localparam int TCC_PIN_OUTEN = 1;
  // ****************************************
  // Reset values and timing
  // ****************************************
  localparam logic [7:0] TCC_RST_BYTE = 8'h00;
  localparam logic [15:0] TCC_RST_WORD = 16'h0000;
  localparam int TCC_FILT_SAMPLES = 4;
  localparam logic [1:0] TCC_RESP_OKAY = 2'h0;
  localparam logic [1:0] TCC_RESP_SLVERR = 2'h2;
  // Waveform modes that take top from the capture register
  localparam logic [3:0] TCC_WGM_CAPTOP_A = 4'hC;
  localparam logic [3:0] TCC_WGM_CAPTOP_B = 4'hE;
  localparam logic [3:0] TCC_WGM_CAPTOP_C = 4'h8;
  localparam logic [3:0] TCC_WGM_CAPTOP_D = 4'hA;
endpackage : tcc_pkg

// *** hdl/tcc_input_filter.sv ***
// Input conditioning for the capture path: synchroniser, filter, edge.
// Assumes inputs from outside the clock domain; filter runs on aclk.
`timescale 1ns/1ps
module tcc_input_filter (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Control
  input wire logic enable,
  input wire logic filter_on,
  input wire logic rising_sel,
  // Signal
  input wire logic raw_in,
  output logic edge_pulse
);
  logic sync1_q;
  logic sync2_q;
  logic [2:0] hist_q;
  logic filt_q;
  logic prev_q;
  logic level;

  // ****************************************
  // Two-stage synchroniser
  // ****************************************
  // shared sampling stage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end else begin
      sync1_q <= raw_in;
      sync2_q <= sync1_q;
    end
  end

  // ****************************************
  // Noise filter
  // ****************************************
  // four agreeing samples; on system clock, no prescaler
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_q <= 3'h0;
      filt_q <= 1'b0;
    end else begin
      // Current sample counts as the fourth, so the delay is exactly four
      hist_q <= {hist_q[1:0], sync2_q};
      if ({hist_q, sync2_q} == 4'hF) begin
        filt_q <= 1'b1;
      end else if ({hist_q, sync2_q} == 4'h0) begin
        filt_q <= 1'b0;
      end
    end
  end

  // filter adds four cycles; bypass when off
  assign level = filter_on ? filt_q : sync2_q;

  // ****************************************
  // Edge detector
  // ****************************************
  // single edge detector; gated by mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prev_q <= 1'b0;
      edge_pulse <= 1'b0;
    end else begin
      prev_q <= level;
      edge_pulse <= enable & (rising_sel ? (level & ~prev_q) : (~level & prev_q));
    end
  end
endmodule : tcc_input_filter

// *** hdl/tcc_compare_chan.sv ***
// One compare channel: equality match and waveform output.
// Assumes counter and compare value on the same clock.
`timescale 1ns/1ps
module tcc_compare_chan (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Timer state
  input wire logic tick,
  input wire logic [15:0] count,
  input wire logic [15:0] compare,
  input wire logic at_bottom,
  // Mode
  input wire logic [3:0] wave_mode,
  input wire logic [1:0] out_mode,
  // Results
  output logic match_pulse,
  output logic wave_out
);
  logic match;

  assign match = (count == compare);

  // flag event on the next timer tick
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      match_pulse <= 1'b0;
    end else begin
      match_pulse <= tick & match;
    end
  end

  // ****************************************
  // Waveform output
  // ****************************************
  // output by mode fields; PWM modes with out_mode[1] set load ~out_mode[0] at bottom
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wave_out <= 1'b0;
    end else if (tick) begin
      if (wave_mode == 4'h0 || wave_mode == 4'h4 || wave_mode == 4'hC) begin
        if (match) begin
          case (out_mode)
            2'h1: wave_out <= ~wave_out;
            2'h2: wave_out <= 1'b0;
            2'h3: wave_out <= 1'b1;
            default: wave_out <= wave_out;
          endcase
        end
      end else if (out_mode[1]) begin
        // Simplified PWM: invert on match, restore at bottom
        if (match) begin
          wave_out <= out_mode[0];
        end else if (at_bottom) begin
          wave_out <= ~out_mode[0];
        end
      end
    end
  end
endmodule : tcc_compare_chan

// *** bench/tcc_capture_src.sv ***
// Far side of the capture input: an outside source and the pad wire.
// Assumes no pull on the pad; the port driver wins while enabled.
`timescale 1ns/1ps
module tcc_capture_src (
  // Outside source
  input wire logic level,
  // Port driver of the block
  input wire logic pad_out,
  input wire logic pad_oe,
  // Wire seen by the block
  output logic pin
);
  assign pin = pad_oe ? pad_out : level;
endmodule : tcc_capture_src

// *** bench/tcc_asserts.sv ***
// Checker on the tcc_top ports: bus answers, flag clears, pad enable.
// Assumes the one aclk domain and its synchronous active-low reset.
`timescale 1ns/1ps
module tcc_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bus
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Service acknowledges and requests
  input wire logic cmp_a_ack,
  input wire logic cmp_b_ack,
  input wire logic cap_ack,
  input wire logic cmp_a_irq,
  input wire logic cmp_b_irq,
  input wire logic cap_irq,
  // Pad
  input wire logic capture_pin_oe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ****************
  // Assertions
  // ****************
  chk_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  chk_rd_hold: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_err_zero: assert property (
    s_axi_rvalid && s_axi_rresp == tcc_pkg::TCC_RESP_SLVERR |-> s_axi_rdata == 32'h0)
    else $error("error read not zero");
  chk_wr_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  chk_ack_a: assert property (cmp_a_ack |-> ##2 !cmp_a_irq)
    else $error("compare A not cleared");
  chk_ack_b: assert property (cmp_b_ack |-> ##2 !cmp_b_irq)
    else $error("compare B not cleared");
  chk_ack_cap: assert property (cap_ack |-> ##2 !cap_irq [*2])
    else $error("capture not cleared");
  chk_oe_write: assert property (!$stable(capture_pin_oe) |-> $past(s_axi_bvalid))
    else $error("pad enable moved alone");
  // Main scenarios reached
  cov_ack: cover property (cmp_a_ack ##2 !cmp_a_irq);
  cov_err: cover property (s_axi_rvalid && s_axi_rresp == tcc_pkg::TCC_RESP_SLVERR);
  cov_cap: cover property ($rose(cap_irq));
endmodule : tcc_asserts

bind tcc_top tcc_asserts chk_i (.*);

// *** bench/tb_timer16_capture_compare.sv ***
// Self-checking bench for tcc_top over AXI4-Lite.
// Assumes the package register map and an outside capture source.
`timescale 1ns/1ps
module tb_timer16_capture_compare;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic level = 1'b0;
  logic cmp = 1'b0;
  logic [2:0] ack = 3'h0;
  logic awready, wready, bvalid, arready, rvalid, pin, pin_out, pin_oe;
  logic [1:0] rresp;
  logic [31:0] rdata;
  logic [2:0] irq;
  int failures = 0;
  int n_tests = 0;

  tcc_top dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_pin_in(pin), .comparator_out(cmp),
    .capture_pin_out(pin_out), .capture_pin_oe(pin_oe),
    .cmp_a_ack(ack[0]), .cmp_b_ack(ack[1]), .cap_ack(ack[2]),
    .cmp_a_irq(irq[0]), .cmp_b_irq(irq[1]), .cap_irq(irq[2]),
    .wave_a(), .wave_b()
  );
  tcc_capture_src src (.level(level), .pad_out(pin_out), .pad_oe(pin_oe), .pin(pin));

  // 25 MHz clock
  initial begin
    forever #20 aclk = ~aclk;
  end

  // ****************
  // Bus and check tasks
  // ****************
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : tally_and_finish

  // A hung handshake counts once, then the run closes
  task automatic stuck;
    failures++;
    tally_and_finish();
  endtask : stuck

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one byte-register write at a time, never interleaved
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50 && (n == 0 || bready); n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bready && bvalid) bready <= 1'b0;
    end
    if (n == 50) stuck();
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50 && (n == 0 || rready); n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rready && rvalid) begin
        rready <= 1'b0;
        d = rdata;
        r = rresp;
      end
    end
    if (n == 50) stuck();
  endtask : rd

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    logic [1:0] r;
    rd(a, d, r);
    chk(d, e);
  endtask : rc

  // Cycles until request k shows; bounded
  task automatic wt(input int k, output int n);
    for (n = 0; n < 40 && irq[k] !== 1'b1; n++) begin
      @(posedge aclk);
    end
    if (n == 40) stuck();
  endtask : wt

  // Settle the pin low, clear the flag, then time a rising capture
  task automatic meas(output int n);
    level <= 1'b0;
    wr(tcc_pkg::TCC_ADDR_FLAG, 32'h20);
    repeat (10) @(posedge aclk);
    level <= 1'b1;
    wt(2, n);
  endtask : meas

  // ****************
  // Scenarios
  // ****************
  task automatic regs_check;
    logic [31:0] d;
    logic [1:0] r;
    rc(tcc_pkg::TCC_ADDR_MASK, 32'h0);
    rd(8'h38, d, r);
    chk(r, tcc_pkg::TCC_RESP_SLVERR);
    chk(d, 32'h0);
    wr(tcc_pkg::TCC_ADDR_CMPA_H, 32'h05);
    wr(tcc_pkg::TCC_ADDR_CMPA_L, 32'h06);
    wr(tcc_pkg::TCC_ADDR_CNT_H, 32'h01);
    wr(tcc_pkg::TCC_ADDR_CNT_L, 32'hFF);
    wr(tcc_pkg::TCC_ADDR_CNT_H, 32'hAB);
    rc(tcc_pkg::TCC_ADDR_CNT_L, 32'hFF);
    rc(tcc_pkg::TCC_ADDR_CNT_H, 32'h01);
    rc(tcc_pkg::TCC_ADDR_CMPA_H, 32'h05);
  endtask : regs_check

  task automatic compare_check;
    int n;
    wr(tcc_pkg::TCC_ADDR_CMPA_H, 32'h02);
    wr(tcc_pkg::TCC_ADDR_CMPA_L, 32'h08);
    wr(tcc_pkg::TCC_ADDR_CMPB_H, 32'h02);
    wr(tcc_pkg::TCC_ADDR_CMPB_L, 32'h0A);
    wr(tcc_pkg::TCC_ADDR_CNT_H, 32'h02);
    wr(tcc_pkg::TCC_ADDR_CNT_L, 32'h00);
    wr(tcc_pkg::TCC_ADDR_FLAG, 32'h06);
    wr(tcc_pkg::TCC_ADDR_MASK, 32'h06);
    wr(tcc_pkg::TCC_ADDR_CTRL_B, 32'h01);
    wt(0, n);
    wt(1, n);
    chk(n, 2);
    wr(tcc_pkg::TCC_ADDR_CTRL_B, 32'h00);
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h06);
    ack <= 3'h3;
    @(posedge aclk);
    ack <= 3'h0;
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h00);
    chk(irq, 3'h0);
  endtask : compare_check

  task automatic capture_check;
    int n;
    wr(tcc_pkg::TCC_ADDR_CNT_H, 32'h12);
    wr(tcc_pkg::TCC_ADDR_CNT_L, 32'h34);
    wr(tcc_pkg::TCC_ADDR_MASK, 32'h20);
    wr(tcc_pkg::TCC_ADDR_CTRL_B, 32'h40);
    level <= 1'b1;
    wt(2, n);
    rc(tcc_pkg::TCC_ADDR_CAP_L, 32'h34);
    rc(tcc_pkg::TCC_ADDR_CAP_H, 32'h12);
    wr(tcc_pkg::TCC_ADDR_FLAG, 32'h20);
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h00);
    wr(tcc_pkg::TCC_ADDR_CNT_H, 32'h00);
    wr(tcc_pkg::TCC_ADDR_CNT_L, 32'h56);
    wr(tcc_pkg::TCC_ADDR_PIN, 32'h02);
    wr(tcc_pkg::TCC_ADDR_PIN, 32'h03);
    wt(2, n);
    rc(tcc_pkg::TCC_ADDR_CAP_L, 32'h56);
    wr(tcc_pkg::TCC_ADDR_PIN, 32'h00);
    ack <= 3'h4;
    @(posedge aclk);
    ack <= 3'h0;
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h00);
  endtask : capture_check

  task automatic filter_check;
    int n0;
    int n1;
    meas(n0);
    wr(tcc_pkg::TCC_ADDR_CTRL_B, 32'hC0);
    meas(n1);
    chk(n1, n0 + 4);
    level <= 1'b0;
    wr(tcc_pkg::TCC_ADDR_FLAG, 32'h20);
    repeat (10) @(posedge aclk);
    level <= 1'b1;
    repeat (3) @(posedge aclk);
    level <= 1'b0;
    repeat (10) @(posedge aclk);
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h00);
    wr(tcc_pkg::TCC_ADDR_ACMP, 32'h04);
    wr(tcc_pkg::TCC_ADDR_FLAG, 32'h20);
    cmp <= 1'b1;
    wt(2, n0);
    rc(tcc_pkg::TCC_ADDR_FLAG, 32'h20);
  endtask : filter_check

  // Reset, then each scenario in turn
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    regs_check();
    compare_check();
    capture_check();
    filter_check();
    tally_and_finish();
  end
endmodule : tb_timer16_capture_compare
